// ===== rtl/lst_tracker.sv
// Advanced-load table and deferred-fault flags for the core.
// Assumes the pipeline presents at most one operation per cycle.
module lst_tracker
    import lst_pkg::*;
(
    input wire logic clk_sys,           // Core clock
    input wire logic srst,              // Synchronous reset
    input wire logic req_valid,         // Operation present
    input wire lst_req_t req,           // Operation fields
    input wire logic inval_all,         // Correctness flush of table
    input wire logic coll_we,           // Collection register write
    input wire logic [63:0] coll_wdata, // Collection write data
    output lst_rsp_t rsp,               // Registered result
    output logic rsp_valid,             // Result pulse
    output logic [63:0] coll_rdata      // Collection register contents
);
    // How the pieces fit together:
    // The pipeline hands over one operation a cycle, and every answer
    // comes back registered in the following cycle. Table lookups and
    // flag reads are therefore done combinationally on the request.
    // The state change that an operation causes becomes visible to the
    // next operation, never to the operation itself.
    // The table is fully associative: any entry can hold any register.
    // A register-indexed direct table would need an entry for each register,
    // not ALT_DEPTH. Either way one register keeps one entry, of any type. Search cost grows
    // with depth, so depth stays a package constant and is kept small.
    // Eviction is round-robin, with no recency tracking. A poor victim
    // only costs a spurious miss, which the check recovers from.
    // Nothing here can keep a stale entry alive, so every error made
    // falls on the side of a miss.

    // Table entry storage, fully associative
    logic [ALT_DEPTH-1:0] ent_vld;
    logic [REG_W-1:0] ent_reg [ALT_DEPTH];
    logic [1:0] ent_type [ALT_DEPTH];
    logic [ADDR_W-1:0] ent_addr [ALT_DEPTH];
    logic [3:0] ent_size [ALT_DEPTH];
    logic [ALT_IDX_W-1:0] victim;       // Round-robin eviction pointer
    logic [GR_COUNT-1:0] gr_flag;       // Deferred-fault flags
    logic [63:0] coll;                  // Collection register

    // Address compare granularity:
    // Comparing whole lines instead of exact bytes trims 3 bits off the compare
    // width, at the price of a false hit when a store and a load share
    // a line but no byte. That false hit only costs a recovery, never
    // wrong data, which is the safe direction.

    // Coarse line of an address; bytes in one line are treated as one
    function automatic logic [ADDR_W-1:0] line_of(
        input logic [ADDR_W-1:0] a);
        line_of = a >> ALT_GRAN;
    endfunction

    // Conservative overlap: compares whole lines spanned
    function automatic logic overlaps(input logic [ADDR_W-1:0] a0,
        input logic [3:0] s0, input logic [ADDR_W-1:0] a1,
        input logic [3:0] s1);
        logic [ADDR_W-1:0] e0;
        logic [ADDR_W-1:0] e1;
        e0 = a0 + ((ADDR_W'(1) << s0) - ADDR_W'(1));
        e1 = a1 + ((ADDR_W'(1) << s1) - ADDR_W'(1));
        overlaps = (line_of(a0) <= line_of(e1)) &&
                   (line_of(a1) <= line_of(e0));
    endfunction

    // Decoded operation kinds and search results.
    // Everything below is combinational on the current request, so
    // it must settle within one core cycle.
    // The deep compare tree is the critical path of the block.
    logic is_adv;                       // Advanced and combined loads; alloc drops faulting combined ones
    logic hit;                          // Register and type matched
    logic [ALT_DEPTH-1:0] same_reg;
    logic [ALT_DEPTH-1:0] store_hit;
    logic free_found;
    logic [ALT_IDX_W-1:0] free_idx;
    logic src_flag;
    logic alloc;

    // Table search and allocation choice.
    // All entries are compared in parallel against the request.
    // The first free slot wins, which keeps the pick deterministic.
    // If no slot is free, the round-robin victim is overwritten.
    // Store overlap is computed for every operation, but it is only
    // applied for stores, spills and the shared floating spill/fill code (LST_OP_FSPILL).
    // The deferred flags of both sources are always read; a source
    // field that an operation does not use should name a clean register.
    always_comb begin
        is_adv = req_valid && (req.op == LST_OP_ADV_LOAD ||
                 req.op == LST_OP_COMB_LOAD);
        hit = 1'b0;
        free_found = 1'b0;
        free_idx = victim;
        for (int i = 0; i < ALT_DEPTH; i++) begin
            // Register number plus type must match
            same_reg[i] = ent_vld[i] && ent_reg[i] == req.dst &&
                          ent_type[i] == req.ltype;
            store_hit[i] = ent_vld[i] &&
                overlaps(ent_addr[i], ent_size[i], req.addr,
                         req.size_log2);
            if (same_reg[i]) begin
                hit = 1'b1;
            end
            if (!ent_vld[i] && !free_found) begin
                free_found = 1'b1;
                free_idx = ALT_IDX_W'(i);
            end
        end
        // Deferred or faulting combined load leaves no entry
        alloc = is_adv && !(req.op == LST_OP_COMB_LOAD && req.fault);
        src_flag = gr_flag[req.src_a] | gr_flag[req.src_b];
    end

    // Table maintenance.
    // Several removals may meet in one cycle. Later assignments of a
    // bit override earlier ones, so the allocation written last wins
    // over the same-register clear for the slot that it fills.
    // A flush clears valid bits and the victim pointer only; stale contents are harmless
    // because every read is qualified by the valid bit.
    // Hazard: a flush drops all outstanding advanced loads at once,
    // so every pending check then misses and recovers.
    // Entry contents have no reset, to save reset fan-out.
    always_ff @(posedge clk_sys) begin
        if (srst || (req_valid && inval_all)) begin
            ent_vld <= '0;              // Correctness flush
            victim <= '0;
        end else if (req_valid) begin
            if (is_adv) begin
                // Older entry for the same register goes away
                for (int i = 0; i < ALT_DEPTH; i++) begin
                    if (ent_vld[i] && ent_reg[i] == req.dst) begin
                        ent_vld[i] <= 1'b0;
                    end
                end
            end
            if (req.op == LST_OP_STORE || req.op == LST_OP_SPILL ||
                req.op == LST_OP_FSPILL) begin
                ent_vld <= ent_vld & ~store_hit;
            end
            if (req.op == LST_OP_CHK_LOAD && !hit) begin
                // Reissued load keeps no entry; conservative choice
                ent_vld <= ent_vld;
            end
            if (alloc) begin
                // Free slot first, else evict by pointer
                ent_vld[free_idx] <= 1'b1;
                ent_reg[free_idx] <= req.dst;
                ent_type[free_idx] <= req.ltype;
                ent_addr[free_idx] <= req.addr;
                ent_size[free_idx] <= req.size_log2;
                if (!free_found) begin
                    victim <= victim + ALT_IDX_W'(1);
                end
            end
        end
    end

    // Deferred-fault flags per general register
    // A set flag means the register holds a token, not data.
    // Speculative loads set or clear the flag of their destination.
    // Speculative computations copy the OR of their source flags.
    // A fill restores the flag from the collection register.
    // Non-speculative computations never create a token; when they
    // read one they fault instead and the destination keeps its flag.
    // Floating registers carry no flag; their token is a value.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gr_flag <= '0;
        end else if (req_valid) begin
            case (req.op)
                LST_OP_SPEC_LOAD, LST_OP_COMB_LOAD: begin
                    // Deferred fault becomes a token
                    gr_flag[req.dst] <= req.fault && req.defer;
                end
                LST_OP_ALU_SPEC: begin
                    gr_flag[req.dst] <= src_flag;
                end
                LST_OP_FILL: begin
                    gr_flag[req.dst] <=
                        coll[req.addr[COLL_MSB:COLL_LSB]];
                end
                LST_OP_ADV_LOAD, LST_OP_LOAD, LST_OP_CHK_LOAD: begin
                    gr_flag[req.dst] <= 1'b0;   // Good data arrives
                end
                LST_OP_ALU: begin
                    if (!src_flag) begin
                        gr_flag[req.dst] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Collection register; software may save and restore it
    // One bit per 8-byte slot of a 512-byte spill area.
    // Limitation: two spill slots 512 bytes apart share one bit,
    // so software must keep a spill area within one such span.
    // A direct write and a spill in one cycle: the spill wins and the
    // write is lost, so software must not write it while spilling.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            coll <= COLL_RESET;
        end else if (req_valid && req.op == LST_OP_SPILL) begin
            coll[req.addr[COLL_MSB:COLL_LSB]] <= gr_flag[req.src_a];
        end else if (coll_we) begin
            coll <= coll_wdata;     // spill has priority
        end
    end
    assign coll_rdata = coll;

    // Registered answer to the pipeline.
    // All fields return to zero in every cycle, so a field that an
    // operation does not drive is never left over from an earlier one.
    // Only one field group is meaningful per operation kind.
    // The answer is one cycle late; the pipeline must stall any
    // consumer that needs it in the same cycle.
    // Redirect always comes with the recovery address of the request.
    // The reissue flag leaves the actual memory access to the pipeline.
    // Test and classify report their result without any fault.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rsp <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp <= '0;
            rsp_valid <= req_valid;
            if (req_valid) begin
                case (req.op)
                    LST_OP_CHK_ADV: begin
                        rsp.redirect <= !hit;
                        rsp.target <= req.target;
                    end
                    LST_OP_CHK_LOAD: begin
                        rsp.reissue <= !hit;
                    end
                    LST_OP_CHK_SPEC: begin
                        rsp.redirect <= gr_flag[req.dst];
                        rsp.target <= req.target;
                    end
                    LST_OP_ALU, LST_OP_STORE: begin
                        rsp.consume_fault <= src_flag;
                    end
                    LST_OP_SPEC_LOAD, LST_OP_COMB_LOAD: begin
                        rsp.load_fault <= req.fault && !req.defer;
                    end
                    LST_OP_LOAD, LST_OP_ADV_LOAD: begin
                        rsp.load_fault <= req.fault;
                    end
                    LST_OP_TEST: begin
                        rsp.test_true <= gr_flag[req.src_a];
                    end
                    LST_OP_FCLASS: begin
                        // Deferred encoding, not a flag
                        rsp.test_true <= req.fr_val == FP_DEFERRED;
                    end
                    LST_OP_SPILL: begin
                        rsp.spill_flag <= gr_flag[req.src_a];
                    end
                    LST_OP_FSPILL: begin
                        rsp.consume_fault <= 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule

// ===== pkg/lst_pkg.sv
// Shared types and constants for the load speculation tracking block.
// Assumes one core clock and a pipeline that presents one operation a cycle.
package lst_pkg;
    localparam int GR_COUNT = 128;          // General registers
    localparam int FR_COUNT = 128;          // Floating-point registers
    localparam int REG_W = 7;               // Register number width
    localparam int ADDR_W = 64;             // Memory address width
    localparam int ALT_DEPTH = 32;          // Table entries
    localparam int ALT_IDX_W = 5;           // Entry index width
    localparam int ALT_GRAN = 3;            // Low address bits ignored
    localparam int COLL_LSB = 3;            // Collection bit select low
    localparam int COLL_MSB = 8;            // Collection bit select high
    localparam logic [63:0] COLL_RESET = 64'h0; // Collection after reset
    localparam logic [81:0] FP_DEFERRED = 82'h1FFFE0000000000000000;
    localparam logic [1:0] TYPE_GR = 2'h0;  // Integer destination
    localparam logic [1:0] TYPE_FR = 2'h1;  // Floating destination

    // Operation codes from the pipeline
    typedef enum logic [3:0] {
        LST_OP_NONE = 4'h0,
        LST_OP_ADV_LOAD = 4'h1,     // advanced_load
        LST_OP_SPEC_LOAD = 4'h2,    // control_spec_load
        LST_OP_COMB_LOAD = 4'h3,    // combined_spec_load
        LST_OP_CHK_LOAD = 4'h4,     // check_load
        LST_OP_CHK_ADV = 4'h5,      // advanced_check_branch
        LST_OP_CHK_SPEC = 4'h6,     // speculation_check_branch
        LST_OP_STORE = 4'h7,        // Ordinary store
        LST_OP_SPILL = 4'h8,        // gr_spill_store
        LST_OP_FILL = 4'h9,         // gr_fill_load
        LST_OP_ALU_SPEC = 4'hA,     // Speculative computation
        LST_OP_ALU = 4'hB,          // Non-speculative computation
        LST_OP_TEST = 4'hC,         // test_deferred_flag
        LST_OP_FCLASS = 4'hD,       // fp_classify
        LST_OP_FSPILL = 4'hE,       // fp_spill_store / fp_fill_load
        LST_OP_LOAD = 4'hF          // Ordinary load
    } lst_op_t;

    typedef struct packed {
        lst_op_t op;
        logic [REG_W-1:0] dst;      // Destination / checked register
        logic [REG_W-1:0] src_a;    // First source
        logic [REG_W-1:0] src_b;    // Second source
        logic [1:0] ltype;          // Load type
        logic [3:0] size_log2;      // Access size, log2 bytes
        logic [ADDR_W-1:0] addr;    // Memory address
        logic [ADDR_W-1:0] target;  // Recovery address
        logic fault;                // Load met a fault
        logic defer;                // Policy defers that fault
        logic [81:0] fr_val;        // Floating value being classified
    } lst_req_t;

    typedef struct packed {
        logic redirect;             // Branch to recovery
        logic [ADDR_W-1:0] target;  // Recovery address
        logic reissue;              // Reissue the load
        logic consume_fault;        // Deferred-flag consumption fault
        logic load_fault;           // Undeferred load fault
        logic test_true;            // Test result
        logic spill_flag;           // Flag for store data path
    } lst_rsp_t;
endpackage

// ===== verification/lst_pipe_model.sv
// Pipeline model: presents one operation, returns the tracker result.
// Assumes the tracker answers one cycle after taking an operation.
module lst_pipe_model
    import lst_pkg::*;
(
    input wire logic clk_sys, // Core clock
    input wire lst_rsp_t rsp, // Tracker result
    input wire logic rsp_valid, // Result pulse
    output lst_req_t req, // Operation fields
    output logic req_valid, // Operation present
    output logic inval_all // Table flush
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_valid = 1'b0;
        req = '0;
        inval_all = 1'b0;
    end
    // Held until taken; idle fields inverted so stale values never match
    task automatic issue(input lst_req_t r, input logic inv,
        output lst_rsp_t o, output logic v);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= r;
        inval_all <= inv;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        req <= ~r;
        inval_all <= 1'b0;
        #1;
        o = rsp;
        v = rsp_valid;
    endtask
endmodule

// ===== verification/lst_tracker_props.sv
// Port properties of the tracker, bound into every instance.
// Assumes one clock and a synchronous active-high reset.
module lst_tracker_props
    import lst_pkg::*;
(
    input wire logic clk_sys, // Core clock
    input wire logic srst, // Reset
    input wire logic req_valid, // Operation present
    input wire lst_req_t req, // Operation fields
    input wire logic inval_all, // Flush
    input wire logic coll_we, // Collection write
    input wire logic [63:0] coll_wdata, // Collection data
    input wire lst_rsp_t rsp, // Result
    input wire logic rsp_valid, // Result pulse
    input wire logic [63:0] coll_rdata // Collection contents
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_answer; req_valid |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("no result");
    property p_target; rsp_valid && rsp.redirect |->
        rsp.target == $past(req.target); endproperty
    a_target: assert property (p_target) else $error("target");
    property p_reissue; rsp_valid && rsp.reissue |->
        $past(req.op) == LST_OP_CHK_LOAD; endproperty
    a_reissue: assert property (p_reissue) else $error("reissue");
    property p_consume; rsp_valid && rsp.consume_fault |->
        $past(req.op) inside {LST_OP_ALU, LST_OP_STORE}; endproperty
    a_consume: assert property (p_consume) else $error("consume");
    property p_quiet; req_valid && req.op inside {LST_OP_TEST,
        LST_OP_FCLASS, LST_OP_FSPILL} |=> !rsp.consume_fault
        && !rsp.load_fault; endproperty
    a_quiet: assert property (p_quiet) else $error("fault");
    property p_defer; req_valid && req.fault && req.defer && req.op inside
        {LST_OP_SPEC_LOAD, LST_OP_COMB_LOAD} |=> !rsp.load_fault;
    endproperty
    a_defer: assert property (p_defer) else $error("deferred");
    property p_spill; req_valid && req.op == LST_OP_SPILL |=>
        coll_rdata[$past(req.addr[COLL_MSB:COLL_LSB])] == rsp.spill_flag;
    endproperty
    a_spill: assert property (p_spill) else $error("spill bit");
    property p_coll; coll_we && !(req_valid && req.op == LST_OP_SPILL)
        |=> coll_rdata == $past(coll_wdata); endproperty
    a_coll: assert property (p_coll) else $error("coll write");
endmodule
bind lst_tracker lst_tracker_props i_props (.clk_sys, .srst, .req_valid,
    .req, .inval_all, .coll_we, .coll_wdata, .rsp, .rsp_valid, .coll_rdata);

// ===== verification/lst_tracker_bench.sv
// Self-checking bench for the load speculation tracker.
// Assumes the pipeline model issues one operation every two cycles.
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module lst_tracker_bench import lst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, srst, coll_we, req_valid, inval_all, rsp_valid, v;
    logic [63:0] coll_wdata, coll_rdata;
    lst_req_t req;
    lst_rsp_t rsp, rs;
    int fail_count = 0, check_count = 0, cycles = 0;
    localparam logic [63:0] A = 64'h1040; // Line-aligned load address
    localparam logic [63:0] S = 64'h2150; // Spill slot, bit 42
    lst_tracker i_dut (.clk_sys, .srst, .req_valid, .req, .inval_all,
        .coll_we, .coll_wdata, .rsp, .rsp_valid, .coll_rdata);
    lst_pipe_model i_pipe (.clk_sys, .rsp, .rsp_valid, .req, .req_valid,
        .inval_all);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard, well above the roughly 70 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One operation; sources equal s, recovery address 4000 plus dst
    task automatic op(input lst_op_t o, input logic [6:0] d, s,
        input logic [63:0] a, input logic [1:0] t = 0, input logic f = 0,
        df = 0, inv = 0, input logic [81:0] fr = '0);
        i_pipe.issue(lst_req_t'{o, d, s, s, t, 4'h3, a, 64'h4000 + 64'(d),
            f, df, fr}, inv, rs, v);
        `CHK(v, 1'b1)
    endtask
    task automatic s_data();
        op(LST_OP_ADV_LOAD, 7'h05, 7'h00, A);
        op(LST_OP_STORE, 7'h00, 7'h00, A + 64'h8);
        op(LST_OP_CHK_ADV, 7'h05, 7'h05, A);
        `CHK(rs.redirect, 1'b0)
        op(LST_OP_CHK_ADV, 7'h05, 7'h05, A, 2'h1);
        `CHK(rs.redirect, 1'b1)
        op(LST_OP_STORE, 7'h00, 7'h00, A + 64'h4);
        op(LST_OP_CHK_ADV, 7'h05, 7'h05, A);
        `CHK(rs.target, 64'h4005)
        op(LST_OP_CHK_LOAD, 7'h05, 7'h05, A);
        `CHK(rs.reissue, 1'b1)
    endtask
    task automatic s_retarget();
        op(LST_OP_ADV_LOAD, 7'h07, 7'h00, A);
        op(LST_OP_ADV_LOAD, 7'h07, 7'h00, A + 64'h100, 2'h1);
        op(LST_OP_CHK_ADV, 7'h07, 7'h07, A);
        `CHK(rs.redirect, 1'b1)
        op(LST_OP_STORE, 7'h00, 7'h00, A);
        op(LST_OP_CHK_ADV, 7'h07, 7'h07, A + 64'h100, 2'h1);
        `CHK(rs.redirect, 1'b0)
        op(LST_OP_NONE, 7'h00, 7'h00, A, 0, 0, 0, 1'b1);
        op(LST_OP_CHK_ADV, 7'h07, 7'h07, A + 64'h100, 2'h1);
        `CHK(rs.redirect, 1'b1)
        op(LST_OP_COMB_LOAD, 7'h0D, 7'h00, A, 0, 1'b1, 1'b1);
        op(LST_OP_CHK_ADV, 7'h0D, 7'h0D, A);
        `CHK(rs.redirect, 1'b1)
    endtask
    task automatic s_ctrl();
        op(LST_OP_SPEC_LOAD, 7'h0E, 7'h00, A, 0, 1'b1, 1'b0);
        `CHK(rs.load_fault, 1'b1)
        op(LST_OP_SPEC_LOAD, 7'h0A, 7'h00, A, 0, 1'b1, 1'b1);
        op(LST_OP_ALU_SPEC, 7'h0B, 7'h0A, A);
        `CHK(rs.consume_fault, 1'b0)
        op(LST_OP_CHK_SPEC, 7'h0B, 7'h0B, A);
        `CHK(rs.target, 64'h400B)
        op(LST_OP_CHK_SPEC, 7'h0C, 7'h0C, A);
        `CHK(rs.redirect, 1'b0)
        op(LST_OP_TEST, 7'h0B, 7'h0B, A);
        `CHK(rs.test_true, 1'b1)
        op(LST_OP_ALU, 7'h0C, 7'h0B, A);
        `CHK(rs.consume_fault, 1'b1)
        op(LST_OP_FCLASS, 7'h00, 7'h00, A, 0, 0, 0, 0, FP_DEFERRED);
        `CHK(rs.test_true, 1'b1)
        op(LST_OP_FSPILL, 7'h01, 7'h01, A, 0, 0, 0, 0, FP_DEFERRED);
        `CHK(rs.load_fault, 1'b0)
    endtask
    task automatic s_spill();
        op(LST_OP_SPILL, 7'h0B, 7'h0B, S);
        `CHK(coll_rdata[42], 1'b1)
        `CHK(rs.spill_flag, 1'b1)
        op(LST_OP_FILL, 7'h14, 7'h00, S);
        op(LST_OP_ALU, 7'h15, 7'h14, A);
        `CHK(rs.consume_fault, 1'b1)
        @(posedge clk_sys);
        coll_we <= 1'b1;
        @(posedge clk_sys);
        coll_we <= 1'b0;
        #1;
        `CHK(coll_rdata, 64'h0)
        op(LST_OP_FILL, 7'h14, 7'h00, S);
        op(LST_OP_ALU, 7'h15, 7'h14, A);
        `CHK(rs.consume_fault, 1'b0)
    endtask
    initial begin
        srst = 1'b1;
        coll_we = 1'b0;
        coll_wdata = 64'h0;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        s_data();
        s_retarget();
        s_ctrl();
        s_spill();
        test_done();
    end
endmodule
